// ===== rtl/bfp_consts.svh
`ifndef BFP_CONSTS_SVH
`define BFP_CONSTS_SVH
// register byte offsets
`define OFF_CTRL       8'h00
`define OFF_PH_THR     8'h04
`define OFF_RES_THR    8'h08
`define OFF_RT_DLY     8'h0C
`define OFF_BK_DLY     8'h10
`define OFF_SIG_MASK   8'h14
`define OFF_DO_MASK    8'h18
`define OFF_STATUS     8'h1C
`define OFF_CNT_BASE   8'h20
`define OFF_EV_STAMP   8'h30
// control field positions
`define CTL_RT_EN      0
`define CTL_FORCE_EN   1
`define CTL_FORCE_LSB  2
`define CTL_MODE_LSB   8
`define CTL_RSEL_LSB   12
// reset values
`define RST_PH_THR     16'h0014
`define RST_RES_THR    16'h04B0
`define RST_RT_DLY     19'h00014
`define RST_BK_DLY     19'h00028
// hysteresis and scaling
`define HYST_PCT       7'h61
`define PCT_FULL       7'h64
`define PH_TO_MAG      4'hA
// timing
`define DLY_STEP_MS    3'h5
`define MS_NS          1000000
`define CLK_PERIOD_NS  4
`endif

// ===== rtl/bfp_pkg.sv
package bfp_pkg;
    typedef enum logic [3:0] {
        MODE_CUR, MODE_DO, MODE_SIG, MODE_CUR_AND_DO, MODE_CUR_OR_DO,
        MODE_CUR_AND_SIG, MODE_CUR_OR_SIG, MODE_SIG_AND_DO, MODE_SIG_OR_DO,
        MODE_ANY, MODE_ALL
    } mode_t;
    typedef enum logic [1:0] {
        RES_NONE, RES_ONE, RES_TWO, RES_CALC
    } res_sel_t;
    typedef enum logic [2:0] {
        COND_NORMAL, COND_START, COND_RETRIP, COND_BACKUP, COND_BLOCKED
    } cond_t;
    typedef struct packed {
        logic start;
        logic retrip;
        logic backup;
        logic blocked;
    } flags_t;
    typedef struct packed {
        flags_t      on;
        flags_t      off;
        logic [31:0] stamp_ms;
        logic [2:0]  fault_phases;
        logic [47:0] currents;
    } event_t;
endpackage

// ===== rtl/breaker_failure_protection.sv
// Summary of operation
// R1: any phase or selected residual above threshold picks up current criterion
// R2: current pick-up releases below 97 percent of phase threshold
// R3: user grades retrip plus breaker time plus release below backup delay
// R4: residual source code: 0 none, 1 input one, 2 input two, 3 calculated
// R5: eleven mode codes 0 to 10 select criteria and combinations
// R6: masked trip signals count only in modes with signal criterion
// R7: masked output relays count only in modes with relay criterion
// R8: forcing enabled overrides state with forced code 0 to 4
// R9: readable condition code 0 normal to 4 blocked
// R10: phase threshold in 0.01 nominal steps, default 0.20
// R11: residual threshold in 0.001 nominal steps, default 1.200
// R12: binary criteria pick up in same evaluation, no delay
// R13: start only while pick-up active and blocking inactive
// R14: blocking input sampled each evaluation before acting on pick-up
// R15: blocking at pick-up gives blocked, no start, no timing
// R16: blocking after start drops start like a pick-up release
// R17: blocking issues time-stamped event with currents and fault type
// R18: blocking must arrive 5 ms before delay expires
// R19: one pick-up starts retrip and backup timers together
// R20: retrip enable, default on, suppresses retrip when off
// R21: retrip after retrip delay, 5 ms steps, default 0.100 s
// R22: backup trip after backup delay, 5 ms steps, default 0.200 s
// R23: output on and off events stamped with 1 ms resolution
// R24: resettable counters of retrip, backup, start, blocked
// R25: AND modes need all criteria, OR modes any
// R26: pick-up release clears timers and drops start, retrip, backup
`timescale 1ns/10ps
`default_nettype none
`include "bfp_consts.svh"
module breaker_failure_protection
    import bfp_pkg::*;
#(
    parameter int MAG_W     = 16,
    parameter int SIG_W     = 16,
    parameter int DO_W      = 8,
    parameter int MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
)(
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output logic [31:0]           prdata,
    output logic                  pslverr,
    input  wire logic [MAG_W-1:0] phase_mag [3],
    input  wire logic [MAG_W-1:0] residual_input_one,
    input  wire logic [MAG_W-1:0] residual_input_two,
    input  wire logic [MAG_W-1:0] calculated_residual,
    input  wire logic [SIG_W-1:0] trip_signals,
    input  wire logic [DO_W-1:0]  relay_controls,
    input  wire logic             block_in,
    output flags_t                flags,
    output event_t                event_out
);
    localparam logic [18:0] MS_CNT = 19'(MS_CYCLES - 1);
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_BLOCK} state_t;

////////////////////////////////////////////////////////////////////////////
// registers
    logic [31:0]      ctrl_q;
    logic [15:0]      ph_thr_q;
    logic [15:0]      res_thr_q;
    logic [18:0]      rt_dly_q;
    logic [18:0]      bk_dly_q;
    logic [SIG_W-1:0] sig_mask_q;
    logic [DO_W-1:0]  do_mask_q;
    logic [31:0]      cnt_q [4];
    logic [31:0]      rd_d;
    logic             hit;
    logic [31:0]      stamp_q;
    logic [2:0]       cond_q;

    wire       setup     = psel & ~penable;
    wire       wr_acc    = psel & penable & pready & pwrite;
    wire       retrip_en = ctrl_q[`CTL_RT_EN];
    wire       force_en  = ctrl_q[`CTL_FORCE_EN];
    wire [2:0] force_st  = ctrl_q[`CTL_FORCE_LSB +: 3];
    wire [3:0] mode      = ctrl_q[`CTL_MODE_LSB +: 4];
    wire [1:0] res_sel   = ctrl_q[`CTL_RSEL_LSB +: 2];
    wire [3:0] cnt_idx   = 4'(paddr[7:2] - 6'(`OFF_CNT_BASE >> 2));

    always_comb
    begin
        hit  = 1'b1;
        rd_d = 32'h0;
        case (paddr)
            `OFF_CTRL:     rd_d = ctrl_q;
            `OFF_PH_THR:   rd_d = {16'h0, ph_thr_q};
            `OFF_RES_THR:  rd_d = {16'h0, res_thr_q};
            `OFF_RT_DLY:   rd_d = {13'h0, rt_dly_q};
            `OFF_BK_DLY:   rd_d = {13'h0, bk_dly_q};
            `OFF_SIG_MASK: rd_d = 32'(sig_mask_q);
            `OFF_DO_MASK:  rd_d = 32'(do_mask_q);
            `OFF_STATUS:   rd_d = {24'h0, flags, 1'b0, cond_q};
            `OFF_EV_STAMP: rd_d = stamp_q;
            default:
            begin
                if (paddr[7:4] == 4'h2 && paddr[1:0] == 2'h0)
                    rd_d = cnt_q[cnt_idx[1:0]];
                else
                    hit = 1'b0;
            end
        endcase
    end

    // no wait state: answer registered from the setup cycle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            prdata  <= (setup && !pwrite) ? rd_d : 32'h0;
            pslverr <= setup & ~hit;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q     <= 32'h1;                                      // [R20]
            ph_thr_q   <= `RST_PH_THR;                                // [R10]
            res_thr_q  <= `RST_RES_THR;                               // [R11]
            rt_dly_q   <= `RST_RT_DLY;                                // [R21]
            bk_dly_q   <= `RST_BK_DLY;                                // [R22]
            sig_mask_q <= '0;
            do_mask_q  <= '0;
        end
        else if (wr_acc && !pslverr)
        begin
            case (paddr)
                `OFF_CTRL:     ctrl_q     <= {18'h0, pwdata[13:0]};
                `OFF_PH_THR:   ph_thr_q   <= pwdata[15:0];
                `OFF_RES_THR:  res_thr_q  <= pwdata[15:0];
                `OFF_RT_DLY:   rt_dly_q   <= pwdata[18:0];
                `OFF_BK_DLY:   bk_dly_q   <= pwdata[18:0];
                `OFF_SIG_MASK: sig_mask_q <= pwdata[SIG_W-1:0];
                `OFF_DO_MASK:  do_mask_q  <= pwdata[DO_W-1:0];
                default:       ;
            endcase
        end
    end

////////////////////////////////////////////////////////////////////////////
// pick-up
    logic [MAG_W-1:0] res_mag;
    logic             cur_pu_q;
    logic [3:0]       over;
    logic [3:0]       under;

    always_comb
    begin
        case (res_sel_t'(res_sel))                                    // [R4]
            RES_ONE:  res_mag = residual_input_one;
            RES_TWO:  res_mag = residual_input_two;
            RES_CALC: res_mag = calculated_residual;
            default:  res_mag = '0;
        endcase
    end

    wire [MAG_W+6:0] rel_lim = (MAG_W+7)'(ph_thr_q) * `PH_TO_MAG * `HYST_PCT;
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_cmp
            wire [MAG_W-1:0] m   = (g < 3) ? phase_mag[g % 3] : res_mag;
            wire [MAG_W+4:0] thr = (g < 3) ? (MAG_W+5)'(ph_thr_q) * `PH_TO_MAG
                                           : (MAG_W+5)'(res_thr_q);
            wire             use_it = (g < 3) || (res_sel != 2'h0);
            assign over[g]  = use_it && ((MAG_W+5)'(m) > thr);        // [R1]
            assign under[g] = !use_it
                              || ((MAG_W+7)'(m) * `PCT_FULL < rel_lim); // [R2]
        end
    endgenerate

    wire cur_pu_d = (|over) | (cur_pu_q & ~(&under));                 // [R2]
    wire sig_hit  = |(trip_signals & sig_mask_q);                      // [R6] [R12]
    wire do_hit   = |(relay_controls & do_mask_q);                     // [R7] [R12]
    logic pu;

    always_comb
    begin
        case (mode_t'(mode))                                          // [R5] [R25]
            MODE_CUR:         pu = cur_pu_q;
            MODE_DO:          pu = do_hit;
            MODE_SIG:         pu = sig_hit;
            MODE_CUR_AND_DO:  pu = cur_pu_q & do_hit;
            MODE_CUR_OR_DO:   pu = cur_pu_q | do_hit;
            MODE_CUR_AND_SIG: pu = cur_pu_q & sig_hit;
            MODE_CUR_OR_SIG:  pu = cur_pu_q | sig_hit;
            MODE_SIG_AND_DO:  pu = sig_hit & do_hit;
            MODE_SIG_OR_DO:   pu = sig_hit | do_hit;
            MODE_ANY:         pu = cur_pu_q | do_hit | sig_hit;
            MODE_ALL:         pu = cur_pu_q & do_hit & sig_hit;
            default:          pu = 1'b0;
        endcase
    end

////////////////////////////////////////////////////////////////////////////
// state, timers, outputs
    state_t      st_q;
    state_t      st_d;
    logic [18:0] pre_q;
    logic [31:0] tmr_q;
    flags_t      fl_d;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            ST_IDLE:  if (pu) st_d = block_in ? ST_BLOCK : ST_RUN;    // [R14] [R15]
            ST_RUN:   if (!pu) st_d = ST_IDLE;                        // [R26]
                      else if (block_in) st_d = ST_BLOCK;             // [R16]
            ST_BLOCK: if (!pu) st_d = ST_IDLE;
            default:  st_d = ST_IDLE;
        endcase
    end

    wire         ms_tick = (pre_q == MS_CNT);
    wire [31:0]  tmr_d   = (st_d != ST_RUN) ? 32'h0                   // [R26]
                           : tmr_q + 32'(ms_tick);                    // [R19]
    wire [21:0]  rt_ms   = 22'(rt_dly_q) * `DLY_STEP_MS;
    wire [21:0]  bk_ms   = 22'(bk_dly_q) * `DLY_STEP_MS;
    wire         run_d   = (st_d == ST_RUN);

    always_comb
    begin
        fl_d.start   = run_d;                                          // [R13]
        fl_d.retrip  = run_d && retrip_en && tmr_d >= 32'(rt_ms);      // [R20] [R21]
        fl_d.backup  = run_d && tmr_d >= 32'(bk_ms);                   // [R22]
        fl_d.blocked = (st_d == ST_BLOCK);                             // [R15]
        if (force_en)                                                  // [R8]
        begin
            fl_d.start   = (force_st == COND_START);
            fl_d.retrip  = (force_st == COND_RETRIP);
            fl_d.backup  = (force_st == COND_BACKUP);
            fl_d.blocked = (force_st == COND_BLOCKED);
        end
    end

    wire [2:0] cond_d = fl_d.backup  ? COND_BACKUP                     // [R9]
                      : fl_d.retrip  ? COND_RETRIP
                      : fl_d.start   ? COND_START
                      : fl_d.blocked ? COND_BLOCKED : COND_NORMAL;
    wire [3:0] rise   = fl_d & ~flags;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cur_pu_q  <= 1'b0;
            st_q      <= ST_IDLE;
            pre_q     <= 19'h0;
            tmr_q     <= 32'h0;
            stamp_q   <= 32'h0;
            cond_q    <= COND_NORMAL;
            flags     <= '0;
            event_out <= '0;
        end
        else
        begin
            cur_pu_q  <= cur_pu_d;
            st_q      <= st_d;
            pre_q     <= ms_tick ? 19'h0 : pre_q + 19'h1;
            tmr_q     <= tmr_d;
            stamp_q   <= stamp_q + 32'(ms_tick);                      // [R23]
            cond_q    <= cond_d;
            flags     <= fl_d;
            event_out.on           <= rise;                           // [R23] [R17]
            event_out.off          <= ~fl_d & flags;
            event_out.stamp_ms     <= stamp_q;
            event_out.fault_phases <= over[2:0];
            event_out.currents     <= 48'({phase_mag[2], phase_mag[1], phase_mag[0]});
        end
    end

    // write to a counter clears it; a same-cycle occurrence still counts
    generate
        for (g = 0; g < 4; g++)
        begin : g_cnt
            wire clr = wr_acc && !pslverr && paddr[7:4] == 4'h2
                       && cnt_idx[1:0] == 2'(g);
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                    cnt_q[g] <= 32'h0;
                else
                    cnt_q[g] <= (clr ? 32'h0 : cnt_q[g]) + 32'(rise[3-g]); // [R24]
            end
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////
// checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_start_unblocked: assert property ( // [R13]
        flags.start && !$past(force_en) |-> $past(pu) && !$past(block_in))
        else $error("start without pick-up or while blocked");
    chk_block_at_pickup: assert property ( // [R15]
        st_q == ST_IDLE && pu && block_in && !force_en
        |=> flags.blocked && !flags.start)
        else $error("blocked pick-up did not give blocked");
    chk_block_drops: assert property ( // [R16]
        st_q == ST_RUN && block_in && !force_en |=> !flags.start && !flags.retrip)
        else $error("start not dropped on blocking");
    chk_release_clears: assert property ( // [R26]
        !pu && !force_en |=> !flags.start && !flags.retrip && !flags.backup
                             && tmr_q == 32'h0)
        else $error("release did not clear outputs");
    chk_retrip_delay: assert property ( // [R21]
        flags.retrip && !$past(force_en) |-> tmr_q >= 32'($past(rt_ms)))
        else $error("retrip before its delay");
    chk_backup_delay: assert property ( // [R22]
        flags.backup && !$past(force_en) |-> tmr_q >= 32'($past(bk_ms))
                                             && flags.start)
        else $error("backup before its delay");
    chk_retrip_off: assert property ( // [R20]
        !retrip_en && !force_en |=> !flags.retrip)
        else $error("retrip while disabled");
    chk_hyst_release: assert property ( // [R2]
        $fell(cur_pu_q) |-> $past(&under) && !$past(|over))
        else $error("current released above hysteresis limit");
    chk_force_code: assert property ( // [R8]
        force_en && force_st == COND_BACKUP |=> flags.backup && cond_q == COND_BACKUP)
        else $error("forced status not applied");
    chk_sig_no_delay: assert property ( // [R12]
        mode == 4'h2 && sig_hit && !block_in && !force_en && st_q != ST_BLOCK
        |=> flags.start)
        else $error("signal pick-up did not start at the next edge");
    chk_cond_prio: assert property ( // [R9]
        flags.backup |-> cond_q == COND_BACKUP)
        else $error("condition code does not show backup trip");

    // each counter steps by one per rising flag unless a write cleared it
    chk_start_count: assert property ( // [R24]
        !$past(wr_acc) |-> cnt_q[0] == $past(cnt_q[0]) + 32'($rose(flags.start)))
        else $error("start counter out of step");
    chk_retrip_count: assert property ( // [R24]
        !$past(wr_acc) |-> cnt_q[1] == $past(cnt_q[1]) + 32'($rose(flags.retrip)))
        else $error("retrip counter out of step");
    chk_backup_count: assert property ( // [R24]
        !$past(wr_acc) |-> cnt_q[2] == $past(cnt_q[2]) + 32'($rose(flags.backup)))
        else $error("backup counter out of step");
    chk_block_count: assert property ( // [R24]
        !$past(wr_acc) |-> cnt_q[3] == $past(cnt_q[3]) + 32'($rose(flags.blocked)))
        else $error("blocked counter out of step");

    cov_retrip: cover property (flags.start ##[1:1000] $rose(flags.retrip));
    cov_backup: cover property ($rose(flags.backup));
    cov_blocked: cover property ($rose(flags.blocked));
    cov_block_in_run: cover property (flags.start ##1 flags.blocked);
    cov_hyst_hold: cover property (cur_pu_q && !(|over) ##1 cur_pu_q);
endmodule
`default_nettype wire

// ===== bench/far_side_model.sv
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
    input  wire logic   clk,
    output logic [15:0] phase_mag [3],
    output logic [15:0] residual_input_one,
    output logic [15:0] residual_input_two,
    output logic [15:0] calculated_residual,
    output logic [15:0] trip_signals,
    output logic [7:0]  relay_controls,
    output logic        block_in
);
    initial
    begin
        phase_mag = '{16'h0000, 16'h0000, 16'h0000};
        residual_input_one = 16'hFFFF;
        residual_input_two = 16'hFFFF;
        calculated_residual = 16'h0000;
        trip_signals = 16'h0000;
        relay_controls = 8'h00;
        block_in = 1'b0;
    end
    // one phase carries the magnitude, the others stay at zero
    task automatic apply(input int p, input logic [15:0] mag, input logic [15:0] sig,
                         input logic [7:0] rel, input logic blk);
        @(posedge clk);
        for (int i = 0; i < 3; i++)
            phase_mag[i] <= (i == p) ? mag : 16'h0000;
        trip_signals <= sig;
        relay_controls <= rel;
        block_in <= blk;
    endtask
endmodule
`default_nettype wire

// ===== bench/breaker_failure_protection_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "bfp_consts.svh"
module breaker_failure_protection_tb import bfp_pkg::*;;
    typedef struct {string nm; logic [31:0] d; logic [31:0] m; logic e;} chk_t;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        pready, pslverr;
    logic [31:0] prdata, lfsr_q = 32'hE737;
    logic [15:0] phase_mag [3];
    logic [15:0] res_one, res_two, res_calc, trip_signals;
    logic [7:0]  relay_controls;
    logic        block_in;
    flags_t      flags;
    event_t      event_out;
    chk_t        exp_q [$];
    int          fail_count = 0, n_compared = 0;

    initial forever #2 clk = ~clk;

    breaker_failure_protection #(.MS_CYCLES(4)) breaker_failure_protection_i (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .phase_mag(phase_mag), .residual_input_one(res_one),
        .residual_input_two(res_two), .calculated_residual(res_calc),
        .trip_signals(trip_signals), .relay_controls(relay_controls),
        .block_in(block_in), .flags(flags), .event_out(event_out));

    far_side_model far_side_model_i (
        .clk(clk), .phase_mag(phase_mag), .residual_input_one(res_one),
        .residual_input_two(res_two), .calculated_residual(res_calc),
        .trip_signals(trip_signals), .relay_controls(relay_controls),
        .block_in(block_in));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            fail_count++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic e);
        exp_q.push_back('{$sformatf("read %h", a), d, m, e});
        apb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wait_bit(input int b, input logic v, input int lim, output int n);
        n = 0;
        while (flags[b] !== v && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= lim)
        begin
            fail_count++;
            $display("CHECK FAILED flags bit %0d expected %b seen %b", b, v, flags[b]);
            end_of_test();
        end
    endtask

    // unmasked noise on the trip lines must not matter
    function automatic logic [15:0] noise();
        lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
        return lfsr_q[15:0] & 16'hFFFE;
    endfunction

    always @(posedge clk)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            chk_t x;
            x = exp_q.pop_front();
            check(x.nm, x.d & x.m, prdata & x.m);
            check({x.nm, " err"}, {31'h0, x.e}, {31'h0, pslverr});
        end

    initial
    begin
        repeat (100000) @(posedge clk);
        fail_count++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        int n;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd(`OFF_CTRL, 32'h0000_0001, 32'hFFFF_FFFF, 1'b0);
        rd(`OFF_PH_THR, 32'h0000_0014, 32'hFFFF_FFFF, 1'b0);
        rd(`OFF_RES_THR, 32'h0000_04B0, 32'hFFFF_FFFF, 1'b0);
        rd(`OFF_RT_DLY, 32'h0000_0014, 32'hFFFF_FFFF, 1'b0);
        rd(`OFF_BK_DLY, 32'h0000_0028, 32'hFFFF_FFFF, 1'b0);
        rd(8'h44, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        $display("test reset values done");
        // retrip 10 ms before backup 20 ms leaves grading margin
        apb(1'b1, `OFF_RT_DLY, 32'h0000_0002);
        apb(1'b1, `OFF_BK_DLY, 32'h0000_0004);
        apb(1'b1, `OFF_SIG_MASK, 32'h0000_0001);
        apb(1'b1, `OFF_DO_MASK, 32'h0000_0001);
        apb(1'b1, `OFF_CTRL, 32'h0000_0201);
        far_side_model_i.apply(0, 16'h0000, noise() | 16'h0001, 8'h00, 1'b0);
        wait_bit(3, 1'b1, 4, n);
        check("start lag", 32'h1, 32'(n <= 2));
        wait_bit(2, 1'b1, 60, n);
        check("retrip time", 32'h1, 32'(n >= 34 && n <= 46));
        wait_bit(1, 1'b1, 60, n);
        check("backup time", 32'h1, 32'(n >= 34 && n <= 46));
        far_side_model_i.apply(0, 16'h0000, 16'h0000, 8'h00, 1'b0);
        wait_bit(3, 1'b0, 4, n);
        check("flags released", 32'h0, 32'(flags));
        for (int k = 0; k < 4; k++)
            rd(8'(8'h20 + 4 * k), 32'(k < 3), 32'hFFFF_FFFF, 1'b0);
        apb(1'b1, 8'h24, 32'h0000_0000);
        rd(8'h24, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
        $display("test timers done");
        far_side_model_i.apply(1, 16'd150, 16'h0001, 8'h00, 1'b1);
        wait_bit(0, 1'b1, 4, n);
        check("block event", 32'h1, 32'(event_out.on));
        check("block currents", 32'h0096_0000, event_out.currents[31:0]);
        repeat (60) @(posedge clk);
        check("blocked flags", 32'h1, 32'(flags));
        far_side_model_i.apply(0, 16'h0000, 16'h0000, 8'h00, 1'b0);
        repeat (6) @(posedge clk);
        far_side_model_i.apply(0, 16'h0000, 16'h0001, 8'h00, 1'b0);
        wait_bit(3, 1'b1, 4, n);
        far_side_model_i.apply(0, 16'h0000, 16'h0001, 8'h00, 1'b1);
        wait_bit(3, 1'b0, 4, n);
        check("block in run", 32'h1, 32'(flags));
        far_side_model_i.apply(0, 16'h0000, 16'h0000, 8'h00, 1'b0);
        $display("test blocking done");
        apb(1'b1, `OFF_CTRL, 32'h0000_0200);
        far_side_model_i.apply(0, 16'h0000, 16'h0001, 8'h00, 1'b0);
        wait_bit(1, 1'b1, 120, n);
        check("retrip disabled", 32'h0, 32'(flags.retrip));
        apb(1'b1, `OFF_CTRL, 32'h0000_0001);
        far_side_model_i.apply(lfsr_q % 3, 16'd250, 16'h0000, 8'h00, 1'b0);
        wait_bit(3, 1'b1, 6, n);
        far_side_model_i.apply(lfsr_q % 3, 16'd198, 16'h0000, 8'h00, 1'b0);
        repeat (6) @(posedge clk);
        check("hysteresis hold", 32'h1, 32'(flags.start));
        far_side_model_i.apply(0, 16'd190, 16'h0000, 8'h00, 1'b0);
        wait_bit(3, 1'b0, 6, n);
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, `OFF_CTRL, 32'h0000_0001 | (s << 12));
            repeat (6) @(posedge clk);
            check("residual source", 32'(s == 1 || s == 2), 32'(flags.start));
        end
        $display("test current done");
        for (int c = 0; c < 5; c++)
        begin
            apb(1'b1, `OFF_CTRL, 32'h0000_0003 | (c << 2));
            rd(`OFF_STATUS, c, 32'h0000_0007, 1'b0);
        end
        for (int m = 0; m < 11; m++)
        begin
            apb(1'b1, `OFF_CTRL, 32'h0000_0001 | (m << 8));
            far_side_model_i.apply(0, 16'h0000, noise() | 16'h0001, 8'h00, 1'b0);
            repeat (3) @(posedge clk);
            check("signal mode", 32'(16'h0344 >> m) & 1, 32'(flags.start));
            far_side_model_i.apply(0, 16'h0000, 16'h0000, 8'hFE, 1'b0);
            repeat (3) @(posedge clk);
            check("relay masked", 32'h0, 32'(flags.start));
            far_side_model_i.apply(0, 16'h0000, 16'h0000, 8'h01, 1'b0);
            repeat (3) @(posedge clk);
            check("relay mode", 32'(16'h0312 >> m) & 1, 32'(flags.start));
            far_side_model_i.apply(0, 16'h0000, 16'h0001, 8'h01, 1'b0);
            repeat (3) @(posedge clk);
            check("signal and relay", 32'(16'h03D6 >> m) & 1, 32'(flags.start));
            far_side_model_i.apply(0, 16'd250, 16'h0001, 8'h01, 1'b0);
            repeat (3) @(posedge clk);
            check("all criteria", 32'h1, 32'(flags.start));
            far_side_model_i.apply(0, 16'h0000, 16'h0000, 8'h00, 1'b0);
            repeat (3) @(posedge clk);
        end
        $display("test modes done");
        end_of_test();
    end
endmodule
`default_nettype wire
